// [verilog/slsled_pkg.sv]
`default_nettype none

package slsled_pkg;

    // ----------------------------------------------------------------
    // Stream geometry and formats
    // ----------------------------------------------------------------
    localparam int NUM_PORTS = 8;
    localparam int GRP3_BITS = 3;
    localparam int GRP2_BITS = 2;
    localparam int FRAME_MAX = NUM_PORTS * GRP3_BITS;
    localparam int IDX_W = $clog2(FRAME_MAX);
    localparam logic [IDX_W-1:0] LAST3_IDX = IDX_W'(NUM_PORTS * GRP3_BITS - 1);
    localparam logic [IDX_W-1:0] LAST2_IDX = IDX_W'(NUM_PORTS * GRP2_BITS - 1);
    localparam logic [IDX_W-1:0] IDX_ZERO = 5'h00;
    localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;

    localparam logic [1:0] FMT_PLAIN3 = 2'h0;
    localparam logic [1:0] FMT_TWO = 2'h1;
    localparam logic [1:0] FMT_BICOL = 2'h2;
    localparam logic [1:0] FMT_RSVD = 2'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int BLINK_FAST_MS = 43;
    localparam int BLINK_SLOW_MS = 120;
    localparam int BLINK_FAST_CYC = BLINK_FAST_MS * CLK_FREQ_KHZ;
    localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_FREQ_KHZ;
    localparam int SHIFT_HALF_CYC = 5;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CTRL_BLINK_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_FMT_LSB = 0;
    localparam int STAT_CAUGHT_BIT = 2;
    localparam int STAT_RUN_BIT = 3;
    localparam int STAT_FCNT_LSB = 8;
    localparam int FCNT_W = 8;
    localparam logic [FCNT_W-1:0] FCNT_ONE = 8'h01;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PORTS-1:0] link;
        logic [NUM_PORTS-1:0] spd100;
        logic [NUM_PORTS-1:0] fullDup;
        logic [NUM_PORTS-1:0] collision;
        logic [NUM_PORTS-1:0] activity;
    } slsled_stat_s;

    typedef struct packed {
        logic spd;
        logic lnk;
        logic col;
    } slsled_grp_s;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01,
        SER_LATCH = 2'b10
    } slsled_ser_e;

endpackage

`default_nettype wire

// [verilog/slsled_blink.sv]
`default_nettype none

module slsled_blink #(
    parameter int unsigned PERIOD_CYC = 100
) (
    input wire logic mclk,
    input wire logic rst,
    output logic phase
);
    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    logic [CW-1:0] cnt_ff;
    logic phase_ff;
    wire wrapNow = (cnt_ff == CNT_LAST);

    // Phase toggles once per blink period.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_ff <= CNT_ZERO;
            phase_ff <= 1'b0;
        end
        else if (wrapNow)
        begin
            cnt_ff <= CNT_ZERO;
            phase_ff <= ~phase_ff;
        end
        else
        begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    assign phase = phase_ff;

endmodule

`default_nettype wire

// [verilog/slsled_port_enc.sv]
`default_nettype none

module slsled_port_enc
    import slsled_pkg::*;
(
    input wire logic [1:0] fmt,
    input wire logic link,
    input wire logic spd100,
    input wire logic fullDup,
    input wire logic collision,
    input wire logic activity,
    input wire logic blink,
    output slsled_pkg::slsled_grp_s grp
);
    wire bicol = (fmt == FMT_BICOL);
    wire linkOn = link & ~(activity & blink);
    wire lnkPlain = ~linkOn;
    wire lnkBicol = link & (spd100 ? linkOn : ~linkOn);
    wire spdBit = link ? ~spd100 : ~bicol;
    wire colBit = collision ? blink : ~fullDup;

    assign grp.col = colBit;
    assign grp.lnk = bicol ? lnkBicol : lnkPlain;
    assign grp.spd = spdBit;

endmodule

`default_nettype wire

// [verilog/slsled_top.sv]
// What this block does
// - Latch format pins at reset: 3-bit, 2-bit, bi-colour.
// - 3-bit groups: collision/duplex, link/activity, speed.
// - 2-bit groups: speed first, then link/activity.
// - Ports sent in order, port zero to seven.
// - All bits active low except the bi-colour link/speed pair.
// - Collision/duplex low full duplex, high half.
// - Collision makes collision/duplex blink at period.
// - Plain 3-bit: link/activity low while linked.
// - Bi-colour pair: none, 100Mb/s, 10Mb/s codes.
// - Traffic makes link/activity blink at period.
// - Speed low at 100Mb/s, high at 10Mb/s.
// - Blink select zero gives 120 ms period.
// - Speed bit never follows blink period select.
`default_nettype none

module slsled_top
    import slsled_pkg::*;
#(
    parameter int unsigned BLINK_FAST_CYCLES = BLINK_FAST_CYC,
    parameter int unsigned BLINK_SLOW_CYCLES = BLINK_SLOW_CYC,
    parameter int unsigned SHIFT_HALF_CYCLES = SHIFT_HALF_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [1:0] ledFormatSelect,
    input wire slsled_pkg::slsled_stat_s portStat,
    output logic ledShiftClk,
    output logic ledData,
    output logic ledFrame
);
    import slsled_pkg::*;

    localparam int DW = $clog2(SHIFT_HALF_CYCLES + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(SHIFT_HALF_CYCLES - 1);
    localparam logic [DW-1:0] DIV_ZERO = '0;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [1:0] fmt_ff;
    logic caught_ff;
    logic [1:0] ctrl_ff;
    logic [31:0] readdata_ff;
    logic waitrequest_ff;
    logic [DW-1:0] div_ff;
    slsled_ser_e ser_ff;
    slsled_ser_e nxt_ser;
    logic [IDX_W-1:0] bitIdx_ff;
    logic [IDX_W-1:0] nxt_bitIdx;
    logic [FRAME_MAX-1:0] snap_ff;
    logic shiftClk_ff;
    logic nxt_shiftClk;
    logic data_ff;
    logic nxt_data;
    logic frame_ff;
    logic nxt_frame;
    logic [FCNT_W-1:0] fcnt_ff;

    // ----------------------------------------------------------------
    // Format capture
    // ----------------------------------------------------------------
    wire [1:0] fmtMapped = (ledFormatSelect == FMT_RSVD) ?
        FMT_PLAIN3 : ledFormatSelect;

    // The pins are taken on the first edge after reset release and then
    // held until the next reset.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fmt_ff <= FMT_PLAIN3;
            caught_ff <= 1'b0;
        end
        else if (!caught_ff)
        begin
            fmt_ff <= fmtMapped;
            caught_ff <= 1'b1;
        end
    end

    wire twoBit = (fmt_ff == FMT_TWO);
    wire [IDX_W-1:0] lastIdx = twoBit ? LAST2_IDX : LAST3_IDX;

    // ----------------------------------------------------------------
    // Blink sources
    // ----------------------------------------------------------------
    logic blinkFast;
    logic blinkSlow;

    slsled_blink #(
        .PERIOD_CYC(BLINK_FAST_CYCLES)
    ) u_blink_fast (
        .mclk(mclk),
        .rst(rst),
        .phase(blinkFast)
    );

    slsled_blink #(
        .PERIOD_CYC(BLINK_SLOW_CYCLES)
    ) u_blink_slow (
        .mclk(mclk),
        .rst(rst),
        .phase(blinkSlow)
    );

    wire blinkPeriodSelect = ctrl_ff[CTRL_BLINK_BIT];
    wire streamEnable = ctrl_ff[CTRL_EN_BIT];
    wire blinkPhase = blinkPeriodSelect ? blinkFast : blinkSlow;

    // ----------------------------------------------------------------
    // Per-port encoding and frame assembly
    // ----------------------------------------------------------------
    slsled_grp_s grp [NUM_PORTS];
    logic [FRAME_MAX-1:0] frame3;
    logic [FRAME_MAX-1:0] frame2;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp = gp + 1)
        begin : g_port
            slsled_port_enc u_enc (
                .fmt(fmt_ff),
                .link(portStat.link[gp]),
                .spd100(portStat.spd100[gp]),
                .fullDup(portStat.fullDup[gp]),
                .collision(portStat.collision[gp]),
                .activity(portStat.activity[gp]),
                .blink(blinkPhase),
                .grp(grp[gp])
            );
            // Lower index leaves first, so port zero leads the frame.
            assign frame3[gp*GRP3_BITS +: GRP3_BITS] =
                {grp[gp].spd, grp[gp].lnk, grp[gp].col};
            assign frame2[gp*GRP2_BITS +: GRP2_BITS] =
                {grp[gp].lnk, grp[gp].spd};
        end
        for (gp = NUM_PORTS * GRP2_BITS; gp < FRAME_MAX; gp = gp + 1)
        begin : g_pad
            assign frame2[gp] = 1'b1;
        end
    endgenerate

    wire [FRAME_MAX-1:0] frameNow = twoBit ? frame2 : frame3;

    // ----------------------------------------------------------------
    // Shift rate divider
    // ----------------------------------------------------------------
    wire tick = (div_ff == DIV_LAST);

    always_ff @(posedge mclk)
    begin
        if (rst || tick)
        begin
            div_ff <= DIV_ZERO;
        end
        else
        begin
            div_ff <= div_ff + DW'(1);
        end
    end

    // ----------------------------------------------------------------
    // Serialiser
    // ----------------------------------------------------------------
    wire atLast = (bitIdx_ff == lastIdx);
    wire startFrame = tick && (ser_ff == SER_IDLE) && streamEnable &&
        caught_ff;
    wire [IDX_W-1:0] idxInc = bitIdx_ff + IDX_ONE;

    // Data changes while the shift clock is low and is sampled by the
    // external registers on its rising edge; the frame marker follows
    // the last rising edge for one half period.
    always_comb
    begin
        nxt_ser = ser_ff;
        nxt_bitIdx = bitIdx_ff;
        nxt_shiftClk = shiftClk_ff;
        nxt_data = data_ff;
        nxt_frame = frame_ff;
        if (tick)
        begin
            case (ser_ff)
                SER_IDLE:
                begin
                    nxt_shiftClk = 1'b0;
                    nxt_frame = 1'b0;
                    if (streamEnable && caught_ff)
                    begin
                        nxt_ser = SER_SHIFT;
                        nxt_bitIdx = IDX_ZERO;
                        nxt_data = frameNow[0];
                    end
                end
                SER_SHIFT:
                begin
                    if (!shiftClk_ff)
                    begin
                        nxt_shiftClk = 1'b1;
                    end
                    else if (atLast)
                    begin
                        nxt_shiftClk = 1'b0;
                        nxt_frame = 1'b1;
                        nxt_ser = SER_LATCH;
                    end
                    else
                    begin
                        nxt_shiftClk = 1'b0;
                        nxt_bitIdx = idxInc;
                        nxt_data = snap_ff[idxInc];
                    end
                end
                SER_LATCH:
                begin
                    nxt_frame = 1'b0;
                    nxt_ser = SER_IDLE;
                end
                default:
                begin
                    nxt_ser = SER_IDLE;
                    nxt_shiftClk = 1'b0;
                    nxt_frame = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ser_ff <= SER_IDLE;
            bitIdx_ff <= IDX_ZERO;
            shiftClk_ff <= 1'b0;
            data_ff <= 1'b1;
            frame_ff <= 1'b0;
        end
        else
        begin
            ser_ff <= nxt_ser;
            bitIdx_ff <= nxt_bitIdx;
            shiftClk_ff <= nxt_shiftClk;
            data_ff <= nxt_data;
            frame_ff <= nxt_frame;
        end
    end

    // The frame is frozen at its start so that one frame never mixes two
    // blink phases or two status samples.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            snap_ff <= '1;
        end
        else if (startFrame)
        begin
            snap_ff <= frameNow;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fcnt_ff <= '0;
        end
        else if (tick && (ser_ff == SER_LATCH))
        begin
            fcnt_ff <= fcnt_ff + FCNT_ONE;
        end
    end

    assign ledShiftClk = shiftClk_ff;
    assign ledData = data_ff;
    assign ledFrame = frame_ff;

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    wire reqValid = read | write;
    wire answerNow = reqValid && !waitrequest_ff;
    wire hitCtrl = (address == REG_CTRL);
    wire hitStatus = (address == REG_STATUS);
    wire ctrlWrite = answerNow && write && hitCtrl && byteenable[0];

    logic [31:0] statusWord;
    always_comb
    begin
        statusWord = RDATA_ZERO;
        statusWord[STAT_FMT_LSB +: 2] = fmt_ff;
        statusWord[STAT_CAUGHT_BIT] = caught_ff;
        statusWord[STAT_RUN_BIT] = (ser_ff != SER_IDLE);
        statusWord[STAT_FCNT_LSB +: FCNT_W] = fcnt_ff;
    end

    wire [31:0] ctrlWord = {30'h0000_0000, ctrl_ff};
    wire [31:0] readMux = hitCtrl ? ctrlWord :
        (hitStatus ? statusWord : RDATA_ZERO);

    // One wait state: waitrequest drops for exactly one cycle per request.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            waitrequest_ff <= 1'b1;
            readdata_ff <= RDATA_ZERO;
        end
        else
        begin
            waitrequest_ff <= ~(reqValid && waitrequest_ff);
            if (read && waitrequest_ff)
            begin
                readdata_ff <= readMux;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_ff <= CTRL_RESET;
        end
        else if (ctrlWrite)
        begin
            ctrl_ff <= writedata[1:0];
        end
    end

    assign readdata = readdata_ff;
    assign waitrequest = waitrequest_ff;

endmodule

`default_nettype wire

// [test/slsled_led_sink.sv]
`default_nettype none

module slsled_led_sink (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ledShiftClk,
    input wire logic ledData,
    input wire logic ledFrame,
    output logic [23:0] frameBits,
    output logic [5:0] frameLen,
    output int frameCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Shift register chain that captures one frame per marker.
    // ----------------------------------------------------------------
    logic [23:0] cap;
    logic [5:0] n;
    logic clkQ;
    logic frmQ;
    always @(posedge mclk)
    begin
        if (rst)
        begin
            n <= 6'h00;
            frameCnt <= 0;
        end
        else if (ledShiftClk && !clkQ && n < 6'h18)
        begin
            cap[n] <= ledData;
            n <= n + 6'h01;
        end
        if (!rst && ledFrame && !frmQ)
        begin
            frameBits <= cap;
            frameLen <= n;
            n <= 6'h00;
            frameCnt <= frameCnt + 1;
        end
        clkQ <= ledShiftClk;
        frmQ <= ledFrame;
    end
endmodule

`default_nettype wire

// [test/slsled_checker.sv]
`default_nettype none

module slsled_checker
    import slsled_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic [1:0] ledFormatSelect,
    input wire logic ledShiftClk,
    input wire logic ledData,
    input wire logic ledFrame
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Bit counter between frame markers.
    // ----------------------------------------------------------------
    logic [5:0] bitCnt_ff;
    logic clkQ_ff;
    logic [5:0] nxt_bitCnt;
    logic [5:0] frameLen;
    assign nxt_bitCnt = ledFrame ? 6'h00
        : bitCnt_ff + {5'h00, ledShiftClk & ~clkQ_ff};
    assign frameLen = (ledFormatSelect == FMT_TWO) ? 6'h10 : 6'h18;
    always_ff @(posedge mclk)
    begin
        clkQ_ff <= rst ? 1'b0 : ledShiftClk;
        bitCnt_ff <= rst ? 6'h00 : nxt_bitCnt;
    end
    // ----------------------------------------------------------------
    // Properties.
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence frameHold;
        ledFrame [*5] ##1 !ledFrame;
    endsequence
    sequence clkHold;
        ledShiftClk [*5] ##1 !ledShiftClk;
    endsequence
    a_bus_answer: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("bus answer late");
    a_bus_single: assert property (!waitrequest |=> waitrequest)
        else $error("bus answer too long");
    a_reset_state: assert property (disable iff (1'b0) rst |=> waitrequest
        && !ledShiftClk && ledData && !ledFrame) else $error("reset state");
    a_data_steady: assert property (ledShiftClk |-> $stable(ledData))
        else $error("data moved while clock high");
    a_frame_clklow: assert property (ledFrame |-> !ledShiftClk)
        else $error("clock high during marker");
    a_frame_width: assert property ($rose(ledFrame) |-> frameHold)
        else $error("marker width wrong");
    a_clk_high: assert property ($rose(ledShiftClk) |-> clkHold)
        else $error("shift clock high time wrong");
    a_frame_len: assert property (
        $rose(ledFrame) |-> bitCnt_ff == frameLen)
        else $error("frame bit count wrong");
    a_frame_next: assert property ($fell(ledFrame) |->
        ##[1:40] $rose(ledShiftClk)) else $error("frames do not repeat");
endmodule

bind slsled_top slsled_checker slsled_checker_i (
    .mclk(mclk),
    .rst(rst),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .ledFormatSelect(ledFormatSelect),
    .ledShiftClk(ledShiftClk),
    .ledData(ledData),
    .ledFrame(ledFrame)
);

`default_nettype wire

// [test/slsled_top_tb.sv]
`default_nettype none

module slsled_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import slsled_pkg::*;
    logic mclk, rst, read, write, waitrequest;
    logic ledShiftClk, ledData, ledFrame;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, q;
    logic [1:0] fmtPins;
    slsled_stat_s portStat;
    logic [23:0] frameBits;
    logic [5:0] frameLen;
    int frameCnt, bad_count, checked;
    // ----------------------------------------------------------------
    // Design, far side and clock.
    // ----------------------------------------------------------------
    slsled_top #(.BLINK_FAST_CYCLES(600), .BLINK_SLOW_CYCLES(1500),
        .SHIFT_HALF_CYCLES(5)) slsled_top_i (.mclk(mclk), .rst(rst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .ledFormatSelect(fmtPins), .portStat(portStat),
        .ledShiftClk(ledShiftClk), .ledData(ledData), .ledFrame(ledFrame));
    slsled_led_sink slsled_led_sink_i (.mclk(mclk), .rst(rst),
        .ledShiftClk(ledShiftClk), .ledData(ledData), .ledFrame(ledFrame),
        .frameBits(frameBits), .frameLen(frameLen), .frameCnt(frameCnt));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic doReset(input logic [1:0] f);
        rst <= 1'b1;
        fmtPins <= f;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic busXfer(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge mclk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
        if (k >= 50)
        begin
            bad_count++;
            results();
        end
    endtask
    task automatic waitFrames(input int n);
        int t, k;
        t = frameCnt + n;
        k = 0;
        while (frameCnt < t && k < n * 2000)
        begin
            @(posedge mclk);
            k++;
        end
        if (frameCnt < t)
        begin
            bad_count++;
            results();
        end
    endtask
    function automatic logic [23:0] expFrame(input logic [1:0] f,
        input slsled_stat_s s);
        logic [23:0] e;
        logic col, lnk, spd;
        e = '0;
        for (int p = 0; p < 8; p++)
        begin
            col = ~s.fullDup[p];
            lnk = ~s.link[p];
            spd = s.link[p] ? ~s.spd100[p] : 1'b1;
            if (f == FMT_BICOL)
            begin
                lnk = s.link[p] & s.spd100[p];
                spd = s.link[p] & ~s.spd100[p];
            end
            if (f == FMT_TWO)
                e[2*p +: 2] = {lnk, spd};
            else
                e[3*p +: 3] = {spd, lnk, col};
        end
        return e;
    endfunction
    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic testFormat(input logic [1:0] f);
        logic [23:0] m;
        doReset(f);
        portStat <= {8'hB6, 8'hCA, 8'h53, 8'h00, 8'h00};
        busXfer(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", 32'h3, q);
        busXfer(1'b0, REG_STATUS, 32'h0);
        m = {22'h000000, (f == FMT_RSVD) ? 2'h0 : f};
        check("format", {8'h00, m} | 32'h4, q & 32'h7);
        busXfer(1'b1, 4'h8, 32'hFF);
        busXfer(1'b0, 4'h8, 32'h0);
        check("unmapped", 32'h0, q);
        waitFrames(2);
        q = (f == FMT_TWO) ? 32'h10 : 32'h18;
        check("length", q, 32'(frameLen));
        m = (f == FMT_TWO) ? 24'h00FFFF : 24'hFFFFFF;
        q = 32'(expFrame(f, portStat));
        check("frame", q, 32'(frameBits & m));
    endtask
    task automatic countToggles(output int lT, output int cT);
        logic pl, pc;
        lT = 0;
        cT = 0;
        waitFrames(1);
        pl = frameBits[1];
        pc = frameBits[3];
        for (int i = 0; i < 12; i++)
        begin
            waitFrames(1);
            lT += (frameBits[1] !== pl);
            cT += (frameBits[3] !== pc);
            pl = frameBits[1];
            pc = frameBits[3];
            q = {30'h0, frameBits[5], frameBits[2]};
            check("speed steady", 32'h2, q);
        end
    endtask
    task automatic testBlink();
        int fl, fc, sl, sc;
        doReset(FMT_PLAIN3);
        portStat <= {8'h03, 8'h01, 8'h00, 8'h02, 8'h01};
        countToggles(fl, fc);
        check("activity blinks", 32'h1, 32'(fl > 0));
        check("collision blinks", 32'h1, 32'(fc > 0));
        busXfer(1'b1, REG_CTRL, 32'h2);
        countToggles(sl, sc);
        check("slow blink", 32'h1, 32'(sl < fl && sl > 0));
    endtask
    initial
    begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'hF;
        fmtPins = 2'h0;
        portStat = '0;
        bad_count = 0;
        checked = 0;
        for (int f = 0; f < 4; f++)
            testFormat(2'(f));
        testBlink();
        results();
    end
endmodule

`default_nettype wire
